// ===== verilog/wake_timer_pkg.sv
// Constants and types shared by the always-on wake timer design.
// What this block does
// RULE1 - Timer keeps running while fabric is powered down
// RULE2 - Fabric supplies 16-bit wake count preset
// RULE3 - Wake timer advances at 1 kHz
// RULE4 - Sleep request drives power switch low
// RULE5 - Test trigger enters test mode
// RULE6 - Calibration tick output at 16 kHz
// RULE7 - Test mode exposes pre-stage power switch value
// RULE8 - Wake strobe high forces power switch on
// RULE9 - Power switch 0 means down, 1 up
// RULE10 - Timer expiry after sleep wakes fabric again
package wake_timer_pkg;

  // ==========================================================================
  // Timing.
  localparam int unsigned clk_hz = 50_000_000;
  localparam int unsigned tick_hz = 1_000;
  localparam int unsigned cal_hz = 16_000;
  // Cycles per tick, rounded down as a shortest period.
  localparam int unsigned tick_cycles = clk_hz / tick_hz;
  // The calibration output toggles twice per period.
  localparam int unsigned cal_half_cycles = clk_hz / (cal_hz * 2);

  // ==========================================================================
  // Widths and reset values.
  localparam int unsigned count_w = 16;
  localparam logic power_down = 1'h0;
  localparam logic power_up = 1'h1;
  localparam logic power_reset = 1'h1;

  typedef enum logic [1:0] {
    st_awake,
    st_sleeping
  } wake_state_t;

endpackage : wake_timer_pkg

// ===== verilog/wake_tick_if.sv
// Interface carrying the tick divider outputs to the main timer.
`timescale 1ns/10ps
`default_nettype none
interface wake_tick_if;
  logic tick;
  logic cal_clk;
  modport source (output tick, output cal_clk);
  modport sink (input tick, input cal_clk);
endinterface : wake_tick_if
`default_nettype wire

// ===== verilog/wake_tick_gen.sv
// Tick divider: 1 kHz timer tick and 16 kHz calibration clock.
`timescale 1ns/10ps
`default_nettype none
module wake_tick_gen #(
  parameter int unsigned tick_div = wake_timer_pkg::tick_cycles,
  parameter int unsigned cal_div = wake_timer_pkg::cal_half_cycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Tick outputs
  wake_tick_if.source ticks
);

  // ==========================================================================
  // Counters.
  logic [31:0] tick_cnt;
  logic [31:0] cal_cnt;
  logic tick;
  logic cal_clk;
  wire tick_wrap = (tick_cnt == 32'(tick_div - 1));
  wire cal_wrap = (cal_cnt == 32'(cal_div - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt <= 32'h0;
      tick <= 1'h0;
    end else begin
      tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1; // RULE3
      tick <= tick_wrap; // RULE3
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_cnt <= 32'h0;
      cal_clk <= 1'h0;
    end else begin
      cal_cnt <= cal_wrap ? 32'h0 : cal_cnt + 32'h1;
      if (cal_wrap) begin
        cal_clk <= ~cal_clk; // RULE6
      end
    end
  end

  assign ticks.tick = tick;
  assign ticks.cal_clk = cal_clk;

endmodule : wake_tick_gen
`default_nettype wire

// ===== verilog/wake_timer.sv
// Always-on wake timer driving the fabric power switch.
`timescale 1ns/10ps
`default_nettype none
module wake_timer #(
  parameter int unsigned count_w = wake_timer_pkg::count_w,
  parameter int unsigned tick_div = wake_timer_pkg::tick_cycles,
  parameter int unsigned cal_div = wake_timer_pkg::cal_half_cycles
) (
  // Clock and reset, from the always-on domain
  input wire logic clk,
  input wire logic arst_n,
  // Fabric side
  input wire logic [count_w-1:0] wake_count,
  input wire logic sleep_req,
  input wire logic test_trigger,
  output logic cal_tick,
  output logic test_power_copy,
  // External side
  input wire logic wake_strobe,
  output logic power_switch
);

  // ==========================================================================
  // Input synchronisers. The fabric may be unpowered or on another clock,
  // so sleep_req, test_trigger and wake_strobe pass two flops before use.
  logic [2:0] sync1;
  logic [2:0] sync2;
  wire [2:0] raw_in = {wake_strobe, test_trigger, sleep_req};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  wire sleep_s = sync2[0];
  wire test_s = sync2[1];
  wire strobe_s = sync2[2];

  // ==========================================================================
  // Tick source.
  wake_tick_if ticks ();

  wake_tick_gen #(
    .tick_div(tick_div),
    .cal_div(cal_div)
  ) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .ticks(ticks)
  );

  // ==========================================================================
  // Sleep state machine. The preset is captured on the sleep edge because
  // the fabric cannot hold it valid once it loses power.
  wake_timer_pkg::wake_state_t state;
  wake_timer_pkg::wake_state_t next_state;
  logic [count_w-1:0] remain;
  logic [count_w-1:0] next_remain;
  logic sleep_prev;
  logic power;
  logic test_mode;
  wire sleep_rise = sleep_s & ~sleep_prev;
  wire expired = ticks.tick && (remain == '0);

  always_comb begin
    next_state = state;
    next_remain = remain;
    case (state)
      wake_timer_pkg::st_awake: begin
        if (sleep_rise && !strobe_s) begin
          next_state = wake_timer_pkg::st_sleeping; // RULE4
          next_remain = wake_count; // RULE2
        end
      end
      wake_timer_pkg::st_sleeping: begin
        if (strobe_s) begin
          next_state = wake_timer_pkg::st_awake; // RULE8
        end else if (expired) begin
          next_state = wake_timer_pkg::st_awake; // RULE10
        end else if (ticks.tick) begin
          next_remain = remain - 1'b1; // RULE1
        end
      end
      default: begin
        next_state = wake_timer_pkg::st_awake;
      end
    endcase
  end

  // Power-on while awake keeps the fabric alive after reset.
  wire next_power = (next_state == wake_timer_pkg::st_sleeping) ?
                    wake_timer_pkg::power_down :
                    wake_timer_pkg::power_up; // RULE9

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= wake_timer_pkg::st_awake;
      remain <= '0;
      sleep_prev <= 1'h0;
      power <= wake_timer_pkg::power_reset;
      test_mode <= 1'h0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      sleep_prev <= sleep_s;
      power <= next_power;
      test_mode <= test_s; // RULE5
    end
  end

  // ==========================================================================
  // Outputs.
  assign power_switch = power;
  assign cal_tick = ticks.cal_clk; // RULE6
  assign test_power_copy = test_mode & power; // RULE7

endmodule : wake_timer
`default_nettype wire

// ===== sim/wake_timer_monitor.sv
// Wake timer port checker.
`timescale 1ns/10ps
`default_nettype none
module wake_timer_monitor #(parameter int unsigned cal_div = 3) (
  input wire logic clk, arst_n, sleep_req, test_trigger,
  input wire logic cal_tick, test_power_copy, wake_strobe,
  input wire logic power_switch
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Counts cycles between calibration edges, since the half period is
  // far longer than a plain delay may reach at the default divider.
  logic [31:0] cal_age;
  logic cal_seen;
  always_ff @(posedge clk) begin
    if (!arst_n) begin
      cal_age <= 32'h0;
      cal_seen <= 1'h0;
    end else if ($changed(cal_tick)) begin
      cal_age <= 32'h1;
      cal_seen <= 1'h1;
    end else begin
      cal_age <= cal_age + 32'h1;
    end
  end
  property p_rst; $rose(arst_n) |-> power_switch; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_str; $rose(wake_strobe) |-> ##[1:5] power_switch; endproperty
  a_str: assert property (p_str) else $error("str");
  property p_slp; $rose(sleep_req) |-> ##[1:5] !power_switch; endproperty
  a_slp: assert property (p_slp) else $error("slp");
  property p_dn; $fell(power_switch) |-> $past(sleep_req, 2); endproperty
  a_dn: assert property (p_dn) else $error("dn");
  property p_cp; (test_trigger && $stable(power_switch))[*5] |->
    test_power_copy == power_switch; endproperty
  a_cp: assert property (p_cp) else $error("cp");
  property p_off; (!test_trigger)[*5] |-> !test_power_copy; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_cal; $changed(cal_tick) && cal_seen |->
    cal_age == 32'(cal_div); endproperty
  a_cal: assert property (p_cal) else $error("cal");
  property p_hld; $changed(cal_tick) |=> !$changed(cal_tick); endproperty
  a_hld: assert property (p_hld) else $error("hld");
endmodule : wake_timer_monitor
bind wake_timer wake_timer_monitor #(.cal_div(cal_div)) mon (.*);
`default_nettype wire

// ===== sim/regulator_model.sv
// Regulator switch and wake source model.
`timescale 1ns/10ps
`default_nettype none
module regulator_model (
  input wire logic clk, kick, power_switch,
  output logic wake_strobe = 1'h0
);
  // Held until the switch answers, so a slow synchroniser never loses it.
  always @(negedge clk)
    wake_strobe <= kick || wake_strobe && !power_switch;
endmodule : regulator_model
`default_nettype wire

// ===== sim/test_wake_timer.sv
// Wake timer bench.
`timescale 1ns/10ps
`default_nettype none
`define chk(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s %h %h", n, e, g); end end
module test_wake_timer;
  logic clk = 1'h0, arst_n = 1'h0, sleep_req = 1'h0, kick = 1'h0, p;
  logic test_trigger = 1'h0;
  logic [15:0] wake_count = 16'h0002;
  wire logic cal_tick, test_power_copy, wake_strobe, power_switch;
  int fails = 0, n_checks = 0, c;
  initial forever #10 clk = ~clk;
  wake_timer #(.tick_div(10), .cal_div(3)) dut (.*);
  regulator_model far (.*);
  task close_out;
    $display("fails %0d n_checks %0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task wait_pw(input logic v);
    for (c = 0; power_switch !== v && c < 60; c++) @(negedge clk);
    fails += int'(c == 60);
    if (c == 60) close_out;
  endtask : wait_pw
  task s_expiry;
    test_trigger = 1'h1;
    sleep_req = 1'h1;
    wait_pw(1'h0);
    wait_pw(1'h1);
    `chk("span", 1'h1, c >= 20 && c <= 32)
    `chk("copy", 1'h1, test_power_copy)
    sleep_req = 1'h0;
  endtask : s_expiry
  task s_cal;
    test_trigger = 1'h0;
    p = cal_tick;
    c = 0;
    repeat (30) begin
      @(negedge clk);
      c += int'(cal_tick !== p);
      p = cal_tick;
    end
    `chk("cal", 10, c)
    `chk("copy_off", 1'h0, test_power_copy)
  endtask : s_cal
  task s_strobe;
    wake_count = 16'hffff;
    sleep_req = 1'h1;
    wait_pw(1'h0);
    kick <= 1'h1;
    @(negedge clk);
    kick <= 1'h0;
    wait_pw(1'h1);
    `chk("strobe", 1'h1, c < 6)
  endtask : s_strobe
  initial begin
    repeat (4) @(negedge clk);
    `chk("reset", 1'h1, power_switch)
    arst_n = 1'h1;
    s_expiry;
    s_cal;
    s_strobe;
    close_out;
  end
endmodule : test_wake_timer
`default_nettype wire
